// ### common/ibc_pkg.sv
// Package: register map, field positions and types of the bus control block
package ibc_pkg;

	// ------------------------------------------------------------
	// Register map (APB byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0]  BUS_CONTROL_ADDR = 8'h00;
	localparam logic [7:0]  BUS_STATUS_ADDR  = 8'h04;
	localparam logic [7:0]  OWN_ADDR_ADDR    = 8'h08;

	// ------------------------------------------------------------
	// Field positions of bus_control
	// ------------------------------------------------------------
	localparam int MODULE_ON_BIT    = 15;
	localparam int HALT_IDLE_BIT    = 13;
	localparam int CLK_RELEASE_BIT  = 12;
	localparam int PMI_ON_BIT       = 11;
	localparam int WIDE_ADDR_BIT    = 10;
	localparam int EDGE_RATE_BIT    = 9;
	localparam int ALT_THRESH_BIT   = 8;
	localparam int BROADCAST_BIT    = 7;
	localparam int STRETCH_BIT      = 6;
	localparam int ACK_VALUE_BIT    = 5;

	// Writable bits; bit 14 is unimplemented, low hardware-cleared go bits
	localparam logic [15:0] CONTROL_WMASK  = 16'hbfe0;
	localparam logic [15:0] CONTROL_RESET  = 16'h1000;
	localparam logic [6:0]  OWN_ADDR_RESET = 7'h00;
	localparam logic [7:0]  BROADCAST_ADDR = 8'h00;
	localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;

	// Slave receive sequencing
	typedef enum {
		IBC_IDLE,
		IBC_ADDR,
		IBC_ADDR_ACK,
		IBC_DATA,
		IBC_DATA_ACK
	} ibc_state_type;

	// Open-drain pin carrier: drive low enables out, one per line
	typedef struct packed {
		logic sclOe;
		logic sdaOe;
	} ibc_pin_drive_type;

endpackage

// ### logic/ibc_bus_control.sv
// Bus control register and slave clock-stretch logic of a two-wire controller
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
//
// How it works
// - Slave writing release bit lets clock go
// - Release bit zero holds clock low while addressed as slave
// - With stretch allowed, writes start/end stretch
// - Broadcast enable raises flag on general call
module ibc_bus_control (
	input  wire logic                      clk,
	input  wire logic                      reset_n,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [7:0]                paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic                      sclIn,
	input  wire logic                      sdaIn,
	output ibc_pkg::ibc_pin_drive_type     pinDrive,
	output logic                           pinsOwned,
	output logic                           broadcastIrq
);
	import ibc_pkg::*;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] sclSync_reg;
	logic [1:0] sdaSync_reg;
	logic       sclLast_reg;
	logic       sdaLast_reg;
	logic [1:0] sclSync_next;
	logic [1:0] sdaSync_next;

	// Two flops before anything looks at the bus lines
	always_comb begin
		sclSync_next = {sclSync_reg[0], sclIn};
		sdaSync_next = {sdaSync_reg[0], sdaIn};
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sclSync_reg <= 2'h3;
			sdaSync_reg <= 2'h3;
			sclLast_reg <= 1'b1;
			sdaLast_reg <= 1'b1;
		end else begin
			sclSync_reg <= sclSync_next;
			sdaSync_reg <= sdaSync_next;
			sclLast_reg <= sclSync_reg[1];
			sdaLast_reg <= sdaSync_reg[1];
		end
	end

	logic scl;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;
	assign scl       = sclSync_reg[1];
	assign sclRise   = scl & ~sclLast_reg;
	assign sclFall   = ~scl & sclLast_reg;
	assign startSeen = scl & sclLast_reg & sdaLast_reg & ~sdaSync_reg[1];
	assign stopSeen  = scl & sclLast_reg & ~sdaLast_reg & sdaSync_reg[1];

	// ------------------------------------------------------------
	// APB register file
	// ------------------------------------------------------------
	logic [15:0] control_reg;
	logic [15:0] control_next;
	logic [6:0]  ownAddr_reg;
	logic [6:0]  ownAddr_next;
	logic        broadcastHit_reg;
	logic        broadcastHit_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic        pready_reg;
	logic        pready_next;
	logic        pslverr_reg;
	logic        pslverr_next;

	logic apbAccess;
	logic apbWrite;
	logic hwRelease;
	logic hwStretch;
	logic gcEvent;
	logic inSlave;
	assign apbAccess = psel & penable & ~pready_reg;
	assign apbWrite  = apbAccess & pwrite;

	// Decoder shared by read and write paths
	function automatic logic addrKnown(input logic [7:0] a);
		addrKnown = (a == BUS_CONTROL_ADDR) || (a == BUS_STATUS_ADDR) ||
			(a == OWN_ADDR_ADDR);
	endfunction

	// One wait state: answer in the cycle after penable rises
	always_comb begin
		control_next      = control_reg;
		ownAddr_next      = ownAddr_reg;
		broadcastHit_next = broadcastHit_reg;
		prdata_next       = prdata_reg;
		pready_next       = apbAccess;
		pslverr_next      = apbAccess & ~addrKnown(paddr);
		if (apbWrite && paddr == BUS_CONTROL_ADDR) begin
			control_next = (control_reg & ~CONTROL_WMASK) |
				(pwdata[15:0] & CONTROL_WMASK);
			// Release bit only settable by software without stretch allow
			if (!control_reg[STRETCH_BIT] && !pwdata[CLK_RELEASE_BIT])
				control_next[CLK_RELEASE_BIT] = control_reg[CLK_RELEASE_BIT];
		end
		if (apbWrite && paddr == OWN_ADDR_ADDR)
			ownAddr_next = pwdata[6:0];
		// Write of one to the flag clears it
		if (apbWrite && paddr == BUS_STATUS_ADDR && pwdata[0])
			broadcastHit_next = 1'b0;
		// Hardware stretch/release after the software write: hardware wins
		if (hwStretch)
			control_next[CLK_RELEASE_BIT] = 1'b0;
		if (hwRelease)
			control_next[CLK_RELEASE_BIT] = 1'b1;
		// Set wins over clear in the same cycle
		if (gcEvent)
			broadcastHit_next = 1'b1;
		if (apbAccess && !pwrite) begin
			case (paddr)
				BUS_CONTROL_ADDR: prdata_next = {16'h0000, control_reg};
				BUS_STATUS_ADDR:  prdata_next = {29'h0, inSlave, scl,
					broadcastHit_reg};
				OWN_ADDR_ADDR:    prdata_next = {25'h0, ownAddr_reg};
				default:          prdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			control_reg      <= CONTROL_RESET;
			ownAddr_reg      <= OWN_ADDR_RESET;
			broadcastHit_reg <= 1'b0;
			prdata_reg       <= 32'h0000_0000;
			pready_reg       <= 1'b0;
			pslverr_reg      <= 1'b0;
		end else begin
			control_reg      <= control_next;
			ownAddr_reg      <= ownAddr_next;
			broadcastHit_reg <= broadcastHit_next;
			prdata_reg       <= prdata_next;
			pready_reg       <= pready_next;
			pslverr_reg      <= pslverr_next;
		end
	end

	// ------------------------------------------------------------
	// Slave receive sequencer
	// ------------------------------------------------------------
	ibc_state_type state_reg;
	ibc_state_type state_next;
	logic [7:0]    rxShift_reg;
	logic [7:0]    rxShift_next;
	logic [3:0]    bitCount_reg;
	logic [3:0]    bitCount_next;
	logic          ackLow_reg;
	logic          ackLow_next;

	logic moduleOn;
	assign moduleOn = control_reg[MODULE_ON_BIT];
	assign inSlave  = (state_reg != IBC_IDLE) && (state_reg != IBC_ADDR);

	// Addressed byte done: stretch on the falling edge after the ack slot
	always_comb begin
		state_next    = state_reg;
		rxShift_next  = rxShift_reg;
		bitCount_next = bitCount_reg;
		ackLow_next   = ackLow_reg;
		hwStretch     = 1'b0;
		hwRelease     = 1'b0;
		gcEvent       = 1'b0;
		if (!moduleOn || stopSeen) begin
			state_next  = IBC_IDLE;
			ackLow_next = 1'b0;
			hwRelease   = ~control_reg[CLK_RELEASE_BIT];
		end else if (startSeen) begin
			state_next    = IBC_ADDR;
			bitCount_next = 4'h0;
			ackLow_next   = 1'b0;
		end else begin
			case (state_reg)
				IBC_ADDR, IBC_DATA: begin
					if (sclRise) begin
						rxShift_next  = {rxShift_reg[6:0], sdaSync_reg[1]};
						bitCount_next = bitCount_reg + 4'h1;
					end
					if (sclFall && bitCount_reg == BITS_PER_BYTE) begin
						bitCount_next = 4'h0;
						if (state_reg == IBC_DATA) begin
							ackLow_next = 1'b1;
							state_next  = IBC_DATA_ACK;
						end else if (rxShift_reg == BROADCAST_ADDR &&
							control_reg[BROADCAST_BIT]) begin
							gcEvent     = 1'b1;
							ackLow_next = 1'b1;
							state_next  = IBC_ADDR_ACK;
						end else if (rxShift_reg[7:1] == ownAddr_reg) begin
							ackLow_next = 1'b1;
							state_next  = IBC_ADDR_ACK;
						end else begin
							state_next = IBC_IDLE;
						end
					end
				end
				IBC_ADDR_ACK, IBC_DATA_ACK: begin
					if (sclFall) begin
						ackLow_next = 1'b0;
						state_next  = IBC_DATA;
						hwStretch   = control_reg[STRETCH_BIT];
					end
				end
				default: state_next = IBC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_reg    <= IBC_IDLE;
			rxShift_reg  <= 8'h00;
			bitCount_reg <= 4'h0;
			ackLow_reg   <= 1'b0;
		end else begin
			state_reg    <= state_next;
			rxShift_reg  <= rxShift_next;
			bitCount_reg <= bitCount_next;
			ackLow_reg   <= ackLow_next;
		end
	end

	// ------------------------------------------------------------
	// Pin drive, all outputs registered
	// ------------------------------------------------------------
	ibc_pin_drive_type pinDrive_reg;
	ibc_pin_drive_type pinDrive_next;
	logic              pinsOwned_reg;
	logic              irq_reg;

	// Clock held low only while release is zero as a slave
	always_comb begin
		pinDrive_next.sclOe = moduleOn & inSlave &
			~control_next[CLK_RELEASE_BIT];
		pinDrive_next.sdaOe = moduleOn & ackLow_next;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pinDrive_reg  <= '0;
			pinsOwned_reg <= 1'b0;
			irq_reg       <= 1'b0;
		end else begin
			pinDrive_reg  <= pinDrive_next;
			pinsOwned_reg <= moduleOn;
			irq_reg       <= broadcastHit_next;
		end
	end

	assign pinDrive     = pinDrive_reg;
	assign pinsOwned    = pinsOwned_reg;
	assign broadcastIrq = irq_reg;
	assign prdata       = prdata_reg;
	assign pready       = pready_reg;
	assign pslverr      = pslverr_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_release_frees_clock;
		@(posedge clk) disable iff (!reset_n)
		control_reg[CLK_RELEASE_BIT] |-> !pinDrive.sclOe;
	endproperty
	a_release_frees_clock: assert property (p_release_frees_clock)
		else $error("Clock driven low while released");

	property p_stretch_holds;
		@(posedge clk) disable iff (!reset_n)
		hwStretch && moduleOn |=> pinDrive.sclOe;
	endproperty
	a_stretch_holds: assert property (p_stretch_holds)
		else $error("Stretch did not hold clock low");

	property p_soft_stretch;
		@(posedge clk) disable iff (!reset_n)
		apbWrite && paddr == BUS_CONTROL_ADDR && control_reg[STRETCH_BIT]
			&& !hwRelease && !hwStretch
		|=> control_reg[CLK_RELEASE_BIT] == $past(pwdata[CLK_RELEASE_BIT]);
	endproperty
	a_soft_stretch: assert property (p_soft_stretch)
		else $error("Release bit not written under stretch allow");

	property p_gc_flag;
		@(posedge clk) disable iff (!reset_n)
		gcEvent |=> broadcastHit_reg ##1 broadcastIrq;
	endproperty
	a_gc_flag: assert property (p_gc_flag)
		else $error("General call not flagged");

	property p_gc_off;
		@(posedge clk) disable iff (!reset_n)
		!control_reg[BROADCAST_BIT] |-> !gcEvent;
	endproperty
	a_gc_off: assert property (p_gc_off)
		else $error("General call seen while disabled");

	property p_disabled_pins;
		@(posedge clk) disable iff (!reset_n)
		!moduleOn |=> !pinDrive.sclOe && !pinDrive.sdaOe && !pinsOwned;
	endproperty
	a_disabled_pins: assert property (p_disabled_pins)
		else $error("Pins driven while module off");

	property p_apb_answer;
		@(posedge clk) disable iff (!reset_n)
		psel && penable && !pready |=> pready ##1 !pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer)
		else $error("APB answer not one cycle");

	property p_owned_follows;
		@(posedge clk) disable iff (!reset_n)
		$rose(moduleOn) |=> pinsOwned;
	endproperty
	a_owned_follows: assert property (p_owned_follows)
		else $error("Pins not taken on enable");

endmodule

// ### tb/ibc_bus_peer.sv
// Two-wire bus master model: drives clock and data through pull-ups
`timescale 1ns/1ps
module ibc_bus_peer (
	input  wire logic clk,
	input  wire logic sclWire,
	input  wire logic sdaWire,
	output logic      sclDrv,
	output logic      sdaDrv
);
	// ------------------------------
	// Line control
	// ------------------------------
	// Both lines released; the clock stands still outside frames
	initial begin
		sclDrv = 1'b1;
		sdaDrv = 1'b1;
	end
	// Half of the 64 ns link period in 8 ns cycles
	task automatic half();
		repeat (4) @(posedge clk);
	endtask
	// Release clock, then wait out any slave stretch (watchdog bounds it)
	task automatic rise();
		sclDrv <= 1'b1;
		@(posedge clk);
		while (sclWire !== 1'b1)
			@(posedge clk);
	endtask
	// Data falls while clock high
	task automatic start();
		sdaDrv <= 1'b0;
		half();
		sclDrv <= 1'b0;
	endtask
	// Data moves one cycle after the fall so it never races the clock
	task automatic clockBit(input logic b, output logic s);
		@(posedge clk);
		sdaDrv <= b;
		repeat (3) @(posedge clk);
		rise();
		half();
		s = sdaWire;
		sclDrv <= 1'b0;
	endtask
	// MSB first, then a released ninth bit for the acknowledge
	task automatic sendByte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clockBit(b[i], s);
		end
		clockBit(1'b1, ack);
	endtask
	// Data rises while clock high
	task automatic stop();
		@(posedge clk);
		sdaDrv <= 1'b0;
		repeat (3) @(posedge clk);
		rise();
		half();
		sdaDrv <= 1'b1;
		half();
	endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the bus control block
`timescale 1ns/1ps
module tb_top;
	import ibc_pkg::*;
	logic              clk = 1'b0;
	logic              reset_n, psel, penable, pwrite, ack;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, rv;
	logic              pready, pslverr, pinsOwned, broadcastIrq, err;
	logic              sclDrv, sdaDrv, sclWire, sdaWire;
	ibc_pin_drive_type pinDrive;
	int                mismatches, total_checks, cycles;

	// ------------------------------
	// Wiring
	// ------------------------------
	// Open-drain lines: anyone pulling low wins
	assign sclWire = sclDrv & ~pinDrive.sclOe;
	assign sdaWire = sdaDrv & ~pinDrive.sdaOe;
	ibc_bus_control uut (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sclIn(sclWire), .sdaIn(sdaWire),
		.pinDrive(pinDrive), .pinsOwned(pinsOwned),
		.broadcastIrq(broadcastIrq));
	ibc_bus_peer peer (.clk(clk), .sclWire(sclWire), .sdaWire(sdaWire),
		.sclDrv(sclDrv), .sdaDrv(sdaDrv));
	always #4 clk = ~clk;
	// Hang guard: tests need well under 5000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	// ------------------------------
	// Helpers
	// ------------------------------
	// APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// Only the bench watchdog bounds this wait
		while (pready !== 1'b1)
			@(posedge clk);
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle cycle: next call never re-raises psel in this step
		@(posedge clk);
	endtask
	task automatic chk(input string nm, input logic [31:0] ex, got);
		total_checks++;
		if (got !== ex) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// Write control word, then let the pins settle
	task automatic ctl(input logic [31:0] d);
		apb(1'b1, BUS_CONTROL_ADDR, d);
		repeat (3) @(posedge clk);
	endtask

	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic test_reset_enable();
		apb(1'b0, BUS_CONTROL_ADDR, 32'h0);
		chk("control reset", {16'h0, CONTROL_RESET}, rv);
		chk("pins at reset", 32'h0, {31'h0, pinsOwned});
		apb(1'b0, 8'h3c, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		chk("unmapped read", 32'h0, rv);
		ctl(32'h8000);
		chk("pins taken", 32'h1, {31'h0, pinsOwned});
		apb(1'b0, BUS_CONTROL_ADDR, 32'h0);
		// Release stays set: zero refused without stretch allow
		chk("release kept", 32'h9000, rv);
		ctl(32'h1000);
		chk("pins returned", 32'h0, {31'h0, pinsOwned});
		$display("test reset_enable done");
	endtask
	task automatic test_stretch();
		apb(1'b1, OWN_ADDR_ADDR, 32'h2a);
		apb(1'b0, OWN_ADDR_ADDR, 32'h0);
		chk("own address", 32'h2a, rv);
		ctl(32'h9040);
		peer.start();
		peer.sendByte(8'h54, ack);
		chk("address ack", 32'h0, {31'h0, ack});
		repeat (8) @(posedge clk);
		chk("stretch held", 32'h1, {31'h0, pinDrive.sclOe});
		apb(1'b0, BUS_CONTROL_ADDR, 32'h0);
		chk("release bit clear", 32'h8040, rv);
		ctl(32'h9040);
		chk("clock released", 32'h0, {31'h0, pinDrive.sclOe});
		ctl(32'h8040);
		chk("soft stretch", 32'h1, {31'h0, pinDrive.sclOe});
		ctl(32'h9040);
		chk("soft release", 32'h0, {31'h0, pinDrive.sclOe});
		peer.stop();
		$display("test stretch done");
	endtask
	task automatic test_broadcast();
		ctl(32'h9080);
		peer.start();
		peer.sendByte(8'h00, ack);
		chk("broadcast ack", 32'h0, {31'h0, ack});
		repeat (8) @(posedge clk);
		chk("broadcast flag", 32'h1, {31'h0, broadcastIrq});
		// Status: addressed, clock line held low by peer, flag set
		apb(1'b0, BUS_STATUS_ADDR, 32'h0);
		chk("status word", 32'h5, rv);
		peer.stop();
		apb(1'b1, BUS_STATUS_ADDR, 32'h1);
		repeat (3) @(posedge clk);
		chk("flag cleared", 32'h0, {31'h0, broadcastIrq});
		ctl(32'h9000);
		peer.start();
		peer.sendByte(8'h00, ack);
		chk("no broadcast ack", 32'h1, {31'h0, ack});
		repeat (8) @(posedge clk);
		chk("no broadcast flag", 32'h0, {31'h0, broadcastIrq});
		peer.stop();
		$display("test broadcast done");
	endtask

	// ------------------------------
	// Sequence and verdict
	// ------------------------------
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		// Extra cycles let the line synchronisers fill
		repeat (3) @(posedge clk);
		test_reset_enable();
		test_stretch();
		test_broadcast();
		tally_and_finish();
	end
endmodule
